/* rip_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module rip_cpu_model (
  input wire logic mclk,
  input wire logic setI,
  input wire logic setX,
  input wire logic reqValid,
  input wire logic [4:0] reqId,
  output logic cpuIMask = 1'b1,
  output logic cpuXMask = 1'b1,
  output logic irqClear = 1'b0
);
  // masks follow software one cycle late, like a flag update
  always @(posedge mclk) begin
    cpuIMask <= setI;
    cpuXMask <= setX;
    irqClear <= reqValid && reqId == 5'd0 && !cpuIMask;
  end
endmodule
`default_nettype wire

/* rip_defs.vh */
`ifndef RIP_DEFS_VH
`define RIP_DEFS_VH
`define RIP_HIGHEST_PRIORITY_SELECT_OFS 12'h03c
`define RIP_SYSCTL_OFS 12'h040
`define RIP_STATUS_OFS 12'h044
`define RIP_PSEL_RST 5'h06
`define RIP_PSEL_LSB 0
`define RIP_MDA_BIT 5
`define RIP_SPECIAL_MODE_BIT_BIT 6
`define RIP_BOOT_ROM_READ_BIT 7
`define RIP_IRQ_EDGE_SELECT_BIT 0
`define RIP_DLY_BIT 1
`define RIP_CME_BIT 2
`define RIP_FORCED_CLOCK_MONITOR_BIT 3
`define RIP_NVPGM_BIT 4
`define RIP_BOOT_LO 16'hbe40
`define RIP_BOOT_HI 16'hbfff
`define RIP_PAGE_NORM 8'hff
`define RIP_PAGE_SPEC 8'hbf
`define RIP_VEC_RESET 8'hfe
`define RIP_VEC_CLKMON 8'hfc
`define RIP_VEC_WDOG 8'hfa
`define RIP_VEC_NMI 8'hf4
`define RIP_VEC_ILLOP 8'hf8
`define RIP_VEC_IRQ 8'hf2
`define RIP_VEC_RTI 8'hf0
`define RIP_VEC_IC1 8'hee
`define RIP_VEC_IC2 8'hec
`define RIP_VEC_IC3 8'hea
`define RIP_VEC_OC1 8'he8
`define RIP_VEC_OC2 8'he6
`define RIP_VEC_OC3 8'he4
`define RIP_VEC_OC4 8'he2
`define RIP_VEC_IC4OC5 8'he0
`define RIP_VEC_SC2 8'hd4
`define RIP_VEC_SC3 8'hd2
`define RIP_VEC_TOF 8'hde
`define RIP_VEC_PAOV 8'hdc
`define RIP_VEC_PAI 8'hda
`define RIP_VEC_SPI 8'hd8
`define RIP_VEC_SC1 8'hd6
`define RIP_RESP_OK 2'b00
`define RIP_RESP_ERR 2'b10
`endif

/* rip_resolver.v */
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "rip_defs.vh"
module rip_resolver #(
  parameter NSRC = 17
) (
  input wire mclk,
  input wire sys_rst,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire mode_pin_a,
  input wire mode_pin_b,
  input wire cpuIMask,
  input wire cpuXMask,
  input wire porReq,
  input wire clkFailReq,
  input wire watchdogReq,
  input wire nonmaskable_irq_pin,
  input wire illegalOpReq,
  input wire irqPinLow,
  input wire irqClear,
  input wire [NSRC-1:0] srcPending,
  input wire [NSRC-1:0] srcEnable,
  input wire [15:0] cpuAddr,
  output reg reqValid,
  output reg [4:0] reqId,
  output reg [15:0] reqVector,
  output reg [15:0] resetVector,
  output wire bootRomSelect,
  output wire specialVariation,
  output wire modeAExpanded,
  output wire stopRecoveryDelay,
  output wire clockMonitorOn,
  output wire nvProgramEnable
);
  // source index 0 is irq; 1..16 follow default rank
  reg bootRomRead;
  reg specialModeBit;
  reg modeABit;
  reg [4:0] prioSelect;
  reg irqEdgeSelect;
  reg stopDelay;
  reg clockMonitorEnable;
  reg forcedClockMonitor;
  reg nvPgm;
  reg rstSeen;
  reg irqPinPrev;
  reg irqEdgeLatch;
  reg [1:0] resetCause;
  reg [4:0] next_reqId;
  reg next_reqValid;
  reg [4:0] promoted;
  reg [4:0] rank;
  reg [NSRC-1:0] active;
  reg [7:0] vecLow;
  reg [7:0] next_vecLow;
  reg awHeld;
  reg wHeld;
  reg [11:0] awAddr;
  reg [31:0] wData;
  reg [3:0] wStrb;
  integer i;
  wire irqActive;
  wire doWrite;
  wire wrHprio;
  wire wrSysctl;
  wire wrStatus;

  // word decode; the two low address bits are ignored
  assign wrHprio = ({awAddr[11:2], 2'b00} == `RIP_HIGHEST_PRIORITY_SELECT_OFS);
  assign wrSysctl = ({awAddr[11:2], 2'b00} == `RIP_SYSCTL_OFS);
  assign wrStatus = ({awAddr[11:2], 2'b00} == `RIP_STATUS_OFS);
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  assign bootRomSelect = bootRomRead && (cpuAddr >= `RIP_BOOT_LO) &&
    (cpuAddr <= `RIP_BOOT_HI);
  assign specialVariation = specialModeBit;
  assign modeAExpanded = modeABit;
  assign stopRecoveryDelay = stopDelay;
  assign clockMonitorOn = clockMonitorEnable || forcedClockMonitor;
  assign nvProgramEnable = nvPgm;
  // level mode suits wired-or; edge mode holds until cpu acknowledges
  assign irqActive = irqEdgeSelect ? irqEdgeLatch : irqPinLow;

  always @(posedge mclk) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 12'h000;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RIP_RESP_OK;
      prioSelect <= `RIP_PSEL_RST;
      irqEdgeSelect <= 1'b0;
      stopDelay <= 1'b1;
      clockMonitorEnable <= 1'b0;
      forcedClockMonitor <= 1'b0;
      nvPgm <= 1'b0;
      rstSeen <= 1'b1;
      bootRomRead <= 1'b0;
      specialModeBit <= 1'b0;
      modeABit <= 1'b0;
    end else begin
      rstSeen <= 1'b0;
      if (rstSeen) begin
        // mode pins caught on the first clock after release
        bootRomRead <= !mode_pin_b && !mode_pin_a;
        specialModeBit <= !mode_pin_b;
        modeABit <= mode_pin_a;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RIP_RESP_OK;
        if (wrHprio) begin
          if (wStrb[0]) begin
            // silent ignore, as the cpu sees no error on a write made while unmasked
            if (cpuIMask) begin
              prioSelect <= wData[4:0];
            end
            if (specialModeBit && !rstSeen) begin
              bootRomRead <= wData[`RIP_BOOT_ROM_READ_BIT];
              specialModeBit <= wData[`RIP_SPECIAL_MODE_BIT_BIT];
              modeABit <= wData[`RIP_MDA_BIT];
            end
          end
        end else if (wrSysctl) begin
          if (wStrb[0]) begin
            irqEdgeSelect <= wData[`RIP_IRQ_EDGE_SELECT_BIT];
            stopDelay <= wData[`RIP_DLY_BIT];
            clockMonitorEnable <= wData[`RIP_CME_BIT];
            // forced monitor sticks until the next reset
            forcedClockMonitor <= forcedClockMonitor ||
              wData[`RIP_FORCED_CLOCK_MONITOR_BIT];
            nvPgm <= wData[`RIP_NVPGM_BIT];
          end
        end else if (!wrStatus) begin
          s_axi_bresp <= `RIP_RESP_ERR;
        end
      end
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RIP_RESP_OK;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RIP_RESP_OK;
        s_axi_rdata <= 32'h00000000;
        case ({s_axi_araddr[11:2], 2'b00})
          `RIP_HIGHEST_PRIORITY_SELECT_OFS: begin
            s_axi_rdata <= {24'h000000, bootRomRead, specialModeBit,
              modeABit, prioSelect};
          end
          `RIP_SYSCTL_OFS: begin
            s_axi_rdata <= {27'h0000000, nvPgm, forcedClockMonitor,
              clockMonitorEnable, stopDelay, irqEdgeSelect};
          end
          `RIP_STATUS_OFS: begin
            s_axi_rdata <= {16'h0000, resetVector[7:0], reqValid,
              2'b00, reqId};
          end
          default: begin
            s_axi_rresp <= `RIP_RESP_ERR;
          end
        endcase
      end
    end
  end

  // edge latch: a new falling edge beats a same-cycle acknowledge
  always @(posedge mclk) begin
    if (sys_rst) begin
      irqPinPrev <= 1'b0;
      irqEdgeLatch <= 1'b0;
    end else begin
      irqPinPrev <= irqPinLow;
      if (irqPinLow && !irqPinPrev) begin
        irqEdgeLatch <= 1'b1;
      end else if (irqClear) begin
        irqEdgeLatch <= 1'b0;
      end
    end
  end

  // cause kept across the reset so the fetch uses the right pair
  always @(posedge mclk) begin
    if (porReq) begin
      resetCause <= 2'd0;
    end else if (clkFailReq) begin
      resetCause <= 2'd1;
    end else if (watchdogReq) begin
      resetCause <= 2'd2;
    end else if (sys_rst) begin
      resetCause <= 2'd0;
    end
  end

  always @* begin
    case (resetCause)
      2'd1: vecLow = `RIP_VEC_CLKMON;
      2'd2: vecLow = `RIP_VEC_WDOG;
      default: vecLow = `RIP_VEC_RESET;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      resetVector <= {`RIP_PAGE_NORM, `RIP_VEC_RESET};
    end else begin
      resetVector <= {specialModeBit ? `RIP_PAGE_SPEC : `RIP_PAGE_NORM,
        vecLow};
    end
  end

  always @* begin
    // codes 00110..10110 map to sources; the rest fall back to irq
    case (prioSelect)
      5'h06: promoted = 5'd0;
      5'h07: promoted = 5'd1;
      5'h08: promoted = 5'd2;
      5'h09: promoted = 5'd3;
      5'h0a: promoted = 5'd4;
      5'h0b: promoted = 5'd5;
      5'h0c: promoted = 5'd6;
      5'h0d: promoted = 5'd7;
      5'h0e: promoted = 5'd8;
      5'h0f: promoted = 5'd9;
      5'h10: promoted = 5'd12;
      5'h11: promoted = 5'd13;
      5'h12: promoted = 5'd14;
      5'h13: promoted = 5'd15;
      5'h14: promoted = 5'd16;
      5'h15: promoted = 5'd10;
      5'h16: promoted = 5'd11;
      default: promoted = 5'd0;
    endcase
  end

  always @* begin
    active = srcPending & srcEnable & {NSRC{!cpuIMask}};
    active[0] = irqActive && !cpuIMask;
    next_reqValid = 1'b0;
    next_reqId = 5'd0;
    rank = 5'd0;
    if (!cpuXMask && nonmaskable_irq_pin) begin
      next_reqValid = 1'b1;
      next_reqId = 5'd17;
    end else if (illegalOpReq) begin
      next_reqValid = 1'b1;
      next_reqId = 5'd18;
    end else if (active[promoted]) begin
      next_reqValid = 1'b1;
      next_reqId = promoted;
    end else begin
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
        if (active[i]) begin
          rank = i[4:0];
        end
      end
      next_reqValid = |active;
      next_reqId = rank;
    end
  end

  // vector from identity alone, never from the promotion
  always @* begin
    case (next_reqId)
      5'd0: next_vecLow = `RIP_VEC_IRQ;
      5'd1: next_vecLow = `RIP_VEC_RTI;
      5'd2: next_vecLow = `RIP_VEC_IC1;
      5'd3: next_vecLow = `RIP_VEC_IC2;
      5'd4: next_vecLow = `RIP_VEC_IC3;
      5'd5: next_vecLow = `RIP_VEC_OC1;
      5'd6: next_vecLow = `RIP_VEC_OC2;
      5'd7: next_vecLow = `RIP_VEC_OC3;
      5'd8: next_vecLow = `RIP_VEC_OC4;
      5'd9: next_vecLow = `RIP_VEC_IC4OC5;
      5'd10: next_vecLow = `RIP_VEC_SC2;
      5'd11: next_vecLow = `RIP_VEC_SC3;
      5'd12: next_vecLow = `RIP_VEC_TOF;
      5'd13: next_vecLow = `RIP_VEC_PAOV;
      5'd14: next_vecLow = `RIP_VEC_PAI;
      5'd15: next_vecLow = `RIP_VEC_SPI;
      5'd16: next_vecLow = `RIP_VEC_SC1;
      5'd17: next_vecLow = `RIP_VEC_NMI;
      5'd18: next_vecLow = `RIP_VEC_ILLOP;
      default: next_vecLow = `RIP_VEC_IRQ;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      reqValid <= 1'b0;
      reqId <= 5'd0;
      reqVector <= 16'hfff2;
    end else begin
      reqValid <= next_reqValid;
      reqId <= next_reqId;
      reqVector <= {`RIP_PAGE_NORM, next_vecLow};
    end
  end
endmodule
`default_nettype wire

/* rip_resolver_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module rip_resolver_monitor #(
  parameter NSRC = 17
) (
  input wire mclk,
  input wire sys_rst,
  input wire mode_pin_a,
  input wire mode_pin_b,
  input wire cpuXMask,
  input wire cpuIMask,
  input wire porReq,
  input wire clkFailReq,
  input wire watchdogReq,
  input wire nonmaskable_irq_pin,
  input wire illegalOpReq,
  input wire [15:0] cpuAddr,
  input wire reqValid,
  input wire [4:0] reqId,
  input wire [15:0] reqVector,
  input wire bootRomSelect,
  input wire specialVariation,
  input wire modeAExpanded,
  input wire stopRecoveryDelay,
  input wire clockMonitorOn,
  input wire nvProgramEnable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // reset causes steer only the reset vector, so keep them out
  wire quiet = !porReq && !clkFailReq && !watchdogReq;
  wire nmi = nonmaskable_irq_pin && !cpuXMask;
  // low vector bytes, source 16 in the top byte
  localparam [135:0] VTAB = {8'hd6, 8'hd8, 8'hda, 8'hdc, 8'hde, 8'hd2,
    8'hd4, 8'he0, 8'he2, 8'he4, 8'he6, 8'he8, 8'hea, 8'hec, 8'hee, 8'hf0,
    8'hf2};
  property p_dly; $fell(sys_rst) |-> stopRecoveryDelay; endproperty
  a_dly: assert property (p_dly) else $error("delay not set");
  property p_cm; $fell(sys_rst) |-> !clockMonitorOn; endproperty
  a_cm: assert property (p_cm) else $error("clock monitor on");
  property p_nv; $fell(sys_rst) |-> !nvProgramEnable; endproperty
  a_nv: assert property (p_nv) else $error("programming on");
  property p_mode; $fell(sys_rst) |=> specialVariation == !$past(mode_pin_b)
    && modeAExpanded == $past(mode_pin_a); endproperty
  a_mode: assert property (p_mode) else $error("mode bits");
  property p_nmi; quiet && nmi |=> reqValid && reqId == 5'd17
    && reqVector == 16'hfff4; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi rank");
  property p_ill; quiet && !nmi && illegalOpReq |=> reqValid
    && reqId == 5'd18 && reqVector == 16'hfff8; endproperty
  a_ill: assert property (p_ill) else $error("trap rank");
  property p_mask; quiet && !nmi && !illegalOpReq && cpuIMask |=> !reqValid;
  endproperty
  a_mask: assert property (p_mask) else $error("mask leak");
  property p_vec; reqValid && reqId < 5'd17 |->
    reqVector == {8'hff, VTAB[{reqId, 3'b000} +: 8]}; endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_boot; bootRomSelect |-> cpuAddr >= 16'hbe40
    && cpuAddr <= 16'hbfff; endproperty
  a_boot: assert property (p_boot) else $error("boot range");
  property p_lock; !specialVariation && !$past(sys_rst) |=>
    $stable(specialVariation) && $stable(modeAExpanded); endproperty
  a_lock: assert property (p_lock) else $error("mode lock");
endmodule
bind rip_resolver rip_resolver_monitor #(.NSRC(NSRC)) i_mon (.mclk(mclk),
  .sys_rst(sys_rst), .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b),
  .cpuXMask(cpuXMask), .cpuIMask(cpuIMask), .porReq(porReq),
  .clkFailReq(clkFailReq), .watchdogReq(watchdogReq),
  .nonmaskable_irq_pin(nonmaskable_irq_pin), .illegalOpReq(illegalOpReq),
  .cpuAddr(cpuAddr), .reqValid(reqValid), .reqId(reqId),
  .reqVector(reqVector), .bootRomSelect(bootRomSelect),
  .specialVariation(specialVariation), .modeAExpanded(modeAExpanded),
  .stopRecoveryDelay(stopRecoveryDelay), .clockMonitorOn(clockMonitorOn),
  .nvProgramEnable(nvProgramEnable));
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rip_defs.vh"
module tb_top;
  logic mclk = 0, rst = 1, awv = 0, wv = 0, bRdy = 0, arv = 0, rRdy = 0;
  logic pa = 0, pb = 0, nmi = 0, ill = 0, irqL = 0, setI = 1, setX = 1;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, q;
  logic [2:0] cause = 0, md;
  logic [15:0] addr = 0, rnd = 16'h0057;
  localparam [135:0] VTAB = {8'hd6, 8'hd8, 8'hda, 8'hdc, 8'hde, 8'hd2,
    8'hd4, 8'he0, 8'he2, 8'he4, 8'he6, 8'he8, 8'hea, 8'hec, 8'hee, 8'hf0,
    8'hf2};
  logic [16:0] pend = 0, ena = 0;
  logic [4:0] psel;
  logic [1:0] resp;
  wire awr, wrd, bv, arr, rv, rqv, brs, spv, mae, srd, cmo, nvp, iM, xM, iClr;
  wire [1:0] br, rr;
  wire [31:0] rd;
  wire [4:0] rid;
  wire [15:0] rvec, rstv;
  integer failures = 0, cmp_count = 0, cyc = 0, k, e;
  rip_resolver i_rip_resolver (.mclk(mclk), .sys_rst(rst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bRdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rRdy), .mode_pin_a(pa),
    .mode_pin_b(pb), .cpuIMask(iM), .cpuXMask(xM), .porReq(cause[2]),
    .clkFailReq(cause[1]), .watchdogReq(cause[0]),
    .nonmaskable_irq_pin(nmi), .illegalOpReq(ill), .irqPinLow(irqL),
    .irqClear(iClr), .srcPending(pend), .srcEnable(ena), .cpuAddr(addr),
    .reqValid(rqv), .reqId(rid), .reqVector(rvec), .resetVector(rstv),
    .bootRomSelect(brs), .specialVariation(spv), .modeAExpanded(mae),
    .stopRecoveryDelay(srd), .clockMonitorOn(cmo), .nvProgramEnable(nvp));
  rip_cpu_model i_rip_cpu_model (.mclk(mclk), .setI(setI), .setX(setX),
    .reqValid(rqv), .reqId(rid), .cpuIMask(iM), .cpuXMask(xM),
    .irqClear(iClr));
  initial forever #5 mclk = ~mclk;
  function automatic [15:0] lfsr(input [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // reference ranking: table scan, promoted source overrides
  function automatic integer expId(input [4:0] ps);
    integer i, s, b;
    begin
      s = (ps >= 6 && ps <= 15) ? ps - 6 : (ps >= 16 && ps <= 20) ? ps - 4
        : (ps == 21 || ps == 22) ? ps - 11 : 0;
      b = -1;
      if (nmi && !setX) b = 17;
      else if (ill) b = 18;
      else if (!setI) begin
        for (i = 16; i >= 0; i = i - 1)
          if (i == 0 ? irqL : pend[i] && ena[i]) b = i;
        if (s == 0 ? irqL : pend[s] && ena[s]) b = s;
      end
      expId = b;
    end
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task wrReg(input [11:0] a, input [7:0] d);
    @(posedge mclk);
    awa <= a; wd <= {24'h0, d}; awv <= 1; wv <= 1; bRdy <= 1;
    do begin
      @(posedge mclk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv);
    resp = br;
    bRdy <= 0;
  endtask
  task rdReg(input [11:0] a);
    @(posedge mclk);
    ara <= a; arv <= 1; rRdy <= 1;
    do begin
      @(posedge mclk);
      if (arr) arv <= 0;
    end while (!rv);
    q = rd; resp = rr;
    rRdy <= 0;
  endtask
  task resetWith(input a, input b, input [2:0] c);
    @(posedge mclk);
    rst <= 1; pa <= a; pb <= b; cause <= c;
    repeat (12) @(posedge mclk);
    rst <= 0;
    repeat (3) @(posedge mclk);
    md = {!b && !a, !b, a};
    chk("rstvec", rstv, {b ? 8'hff : 8'hbf, c[2] ? 8'hfe : c[1] ? 8'hfc
      : 8'hfa});
    chk("special", spv, !b);
    chk("modea", mae, a);
    chk("delay", srd, 1);
    chk("clkmon", {cmo, nvp}, 0);
    cause <= 0;
    rdReg(`RIP_HIGHEST_PRIORITY_SELECT_OFS);
    chk("highest_priority_select", q[7:0], {md, 5'h06});
  endtask
  task conclude;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    for (k = 5; k >= 0; k--)
      resetWith(k[0], k >= 3, k % 3 == 0 ? 3'b111 : k % 3 == 1 ? 3'b011
        : 3'b001);
    rdReg(`RIP_SYSCTL_OFS);
    chk("sysctl", q[4:0], 5'h02);
    rdReg(12'h100);
    chk("unmapped", resp, `RIP_RESP_ERR);
    setI <= 0;
    wrReg(`RIP_HIGHEST_PRIORITY_SELECT_OFS, {md, 5'h0a});
    rdReg(`RIP_HIGHEST_PRIORITY_SELECT_OFS);
    chk("psel", q[4:0], 5'h06);
    // every code twice, boot bit dropped halfway
    for (k = 0; k < 64; k++) begin
      setI <= 1;
      repeat (2) @(posedge mclk);
      psel = k;
      md = {k < 32, 2'b10};
      wrReg(`RIP_HIGHEST_PRIORITY_SELECT_OFS, {md, psel});
      rnd = lfsr(rnd);
      pend <= {rnd, 1'b0};
      rnd = lfsr(rnd);
      ena <= {rnd, 1'b1};
      rnd = lfsr(rnd);
      nmi <= rnd[0] & rnd[1]; ill <= rnd[2] & rnd[3];
      setI <= rnd[4] & rnd[5]; setX <= rnd[6]; irqL <= rnd[7];
      addr <= {7'b1011111, rnd[15:7]};
      repeat (3) @(posedge mclk);
      e = expId(psel);
      chk("valid", rqv, e >= 0);
      if (e >= 0) begin
        chk("id", rid, e);
        chk("vector", rvec, e == 17 ? 16'hfff4 : e == 18 ? 16'hfff8
          : {8'hff, VTAB[e * 8 +: 8]});
      end
      chk("boot", brs, md[2] && addr >= 16'hbe40);
    end
    setI <= 1;
    nmi <= 0;
    ill <= 0;
    irqL <= 0;
    pend <= 0;
    wrReg(`RIP_SYSCTL_OFS, 8'h07);
    chk("cme", cmo, 1);
    // edge mode: one request per falling edge, held pin ignored
    irqL <= 1;
    setI <= 0;
    repeat (3) @(posedge mclk);
    chk("edgeirq", rqv, 1);
    repeat (5) @(posedge mclk);
    chk("edgeonce", rqv, 0);
    irqL <= 0;
    setI <= 1;
    wrReg(`RIP_HIGHEST_PRIORITY_SELECT_OFS, 8'h06);
    wrReg(`RIP_HIGHEST_PRIORITY_SELECT_OFS, 8'he6);
    rdReg(`RIP_HIGHEST_PRIORITY_SELECT_OFS);
    chk("locked", q[7:5], 3'b000);
    conclude;
  end
endmodule
`default_nettype wire
